// [core/cci_interp.sv]
`timescale 1ns/100ps
`include "cci_defs.svh"

// Overview of operation
// - Extension opcodes answer OK with user value
// - Position request answers OK echoing motor mask
// - Armed arrival sends status 128 with mask
// - Position request only accepted when directly issued
// - Type 0 next move, type 1 all
// - Control commands only direct, never stored
// - Opcode 128 halts running program
// - Opcode 129 runs, type 1 from address
// - Opcode 130 executes one instruction then stops
// - Opcode 131 halts and clears program state
// - Opcode 132 enters download, stores later commands
// - Opcode 133 leaves download mode
// - Opcode 134 returns program memory location
// - Opcode 135 reports status selected by type
// - Opcode 136 returns firmware version by type
// - Opcode 137 with 1234 restores, no reply
// - Opcode 255 with 1234 restarts processor
module cci_interp
	import cci_pkg::*;
#(
	parameter int ADDR_W = 16,
	parameter logic [31:0] FW_BIN = 32'h00000001,
	parameter logic [31:0] FW_TXT = 32'h00000002
)
(
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              cmd_valid,
	input  wire logic              cmd_from_prog,
	input  wire logic [7:0]        cmd_op,
	input  wire logic [7:0]        cmd_type,
	input  wire logic [7:0]        cmd_motor,
	input  wire logic [31:0]       cmd_value,
	input  wire logic [31:0]       user_value,
	input  wire logic              move_start,
	input  wire logic              move_done,
	input  wire logic [31:0]       mem_rdata,
	input  wire logic [31:0]       accu,
	input  wire logic [31:0]       xreg,
	input  wire logic              wait_flag,
	input  wire logic [ADDR_W-1:0] prog_counter,
	output logic                   rsp_valid,
	output logic [7:0]             rsp_status,
	output logic [7:0]             rsp_op,
	output logic [31:0]            rsp_value,
	output logic                   rsp_special,
	output logic                   evt_valid,
	output logic [7:0]             evt_status,
	output logic [7:0]             evt_op,
	output logic [31:0]            evt_value,
	output cci_mode_t              prog_mode,
	output logic                   step_pulse,
	output logic                   prog_clear,
	output logic                   pc_load,
	output logic [ADDR_W-1:0]      pc_value,
	output logic                   mem_we,
	output logic [ADDR_W-1:0]      mem_addr,
	output logic [63:0]            mem_wdata,
	output logic                   factory_pulse,
	output logic                   sw_reset_pulse,
	output logic                   exec_pulse
);

	// ==========================================================
	// Command decode
	logic              is_ctrl;
	logic              is_user;
	logic              magic_ok;
	logic              dl_mode;
	cci_act_t          act;
	logic [ADDR_W-1:0] dl_ptr_q;
	cci_mode_t         mode_q;
	cci_arm_t          arm_q;
	logic [7:0]        mask_q;
	logic              move_open_q;
	logic              cmd_direct;
	logic              arm_req;
	logic              rsp_take;

	function automatic logic [ADDR_W-1:0] addr_of(input logic [31:0] v);
		addr_of = v[ADDR_W-1:0];
	endfunction

	function automatic logic in_range(input logic [7:0] op, input logic [7:0] lo,
		input logic [7:0] hi);
		in_range = op >= lo && op <= hi;
	endfunction

	// Pointer field is 16 bits wide whatever ADDR_W is
	function automatic logic [31:0] status_word(input cci_mode_t m, input logic w,
		input logic [ADDR_W-1:0] p);
		status_word                     = '0;
		status_word[`CCI_MODE_POS +: 2] = m;
		status_word[`CCI_WAIT_POS]      = w;
		status_word[15:0]               = 16'(p);
	endfunction

	assign is_ctrl    = in_range(cmd_op, `CCI_OP_STOP, `CCI_OP_POS_REQ)
		|| cmd_op == `CCI_OP_SW_RESET;
	assign is_user    = in_range(cmd_op, `CCI_OP_UF_FIRST, `CCI_OP_UF_LAST);
	assign magic_ok   = cmd_value == `CCI_MAGIC;
	assign dl_mode    = mode_q == CCI_MODE_DL;
	// Commands replayed from a stored program never count as direct
	assign cmd_direct = cmd_valid && !cmd_from_prog;
	assign arm_req    = cmd_direct && !dl_mode && cmd_op == `CCI_OP_POS_REQ;
	// Download stores, factory restore is silent, memory read answers late
	assign rsp_take   = cmd_direct && !(dl_mode && !is_ctrl)
		&& cmd_op != `CCI_OP_READ_MEM && cmd_op != `CCI_OP_FACTORY;

	always_comb
	begin
		act = CCI_ACT_NONE;
		if (cmd_valid && !cmd_from_prog && dl_mode && !is_ctrl)
			act = CCI_ACT_STORE;
		else if (cmd_valid && is_ctrl && !cmd_from_prog)
		begin
			unique case (cmd_op)
				`CCI_OP_STOP:     act = CCI_ACT_STOP;
				`CCI_OP_RUN:      act = CCI_ACT_RUN;
				`CCI_OP_STEP:     act = CCI_ACT_STEP;
				`CCI_OP_RESET:    act = CCI_ACT_RESET;
				`CCI_OP_READ_MEM: act = CCI_ACT_READ_MEM;
				`CCI_OP_FACTORY:  act = magic_ok ? CCI_ACT_FACTORY : CCI_ACT_NONE;
				`CCI_OP_SW_RESET: act = magic_ok ? CCI_ACT_SW_RESET : CCI_ACT_NONE;
				default:          act = CCI_ACT_NONE;
			endcase
		end
		else if (cmd_valid && is_user)
			act = CCI_ACT_USER;
		else if (cmd_valid && !is_ctrl)
			act = CCI_ACT_EXEC;
	end

	// ==========================================================
	// Program mode
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			mode_q <= CCI_MODE_STOP;
		else if (cmd_direct && is_ctrl)
		begin
			// Download mode is left only by its own exit command
			if (cmd_op == `CCI_OP_DL_ENTER)
				mode_q <= CCI_MODE_DL;
			else if (cmd_op == `CCI_OP_DL_EXIT && dl_mode)
				mode_q <= CCI_MODE_STOP;
			else if ((cmd_op == `CCI_OP_STOP || cmd_op == `CCI_OP_RESET) && !dl_mode)
				mode_q <= CCI_MODE_STOP;
			else if (cmd_op == `CCI_OP_RUN && !dl_mode)
				mode_q <= CCI_MODE_RUN;
			else if (cmd_op == `CCI_OP_STEP && !dl_mode)
				mode_q <= CCI_MODE_STEP;
			else if (mode_q == CCI_MODE_STEP)
				mode_q <= CCI_MODE_STOP;
		end
		else if (mode_q == CCI_MODE_STEP)
			mode_q <= CCI_MODE_STOP;
	end

	assign prog_mode = mode_q;

	// ==========================================================
	// Program control pulses
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			step_pulse     <= 1'b0;
			prog_clear     <= 1'b0;
			pc_load        <= 1'b0;
			pc_value       <= '0;
			factory_pulse  <= 1'b0;
			sw_reset_pulse <= 1'b0;
			exec_pulse     <= 1'b0;
		end
		else
		begin
			step_pulse     <= act == CCI_ACT_STEP && !dl_mode;
			prog_clear     <= act == CCI_ACT_RESET;
			pc_load        <= act == CCI_ACT_RUN && !dl_mode && cmd_type == `CCI_TYPE_1;
			if (act == CCI_ACT_RUN && cmd_type == `CCI_TYPE_1)
				pc_value <= addr_of(cmd_value);
			factory_pulse  <= act == CCI_ACT_FACTORY;
			sw_reset_pulse <= act == CCI_ACT_SW_RESET;
			exec_pulse     <= act == CCI_ACT_EXEC;
		end
	end

	// ==========================================================
	// Download pointer and memory port
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			dl_ptr_q <= '0;
		else if (cmd_valid && !cmd_from_prog && cmd_op == `CCI_OP_DL_ENTER)
			dl_ptr_q <= addr_of(cmd_value);
		else if (act == CCI_ACT_STORE)
			dl_ptr_q <= dl_ptr_q + 1'b1;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mem_we    <= 1'b0;
			mem_addr  <= '0;
			mem_wdata <= '0;
		end
		else
		begin
			mem_we <= act == CCI_ACT_STORE;
			if (act == CCI_ACT_STORE)
			begin
				mem_addr  <= dl_ptr_q;
				mem_wdata <= {cmd_op, cmd_type, cmd_motor, 8'h00, cmd_value};
			end
			else if (act == CCI_ACT_READ_MEM)
				mem_addr <= addr_of(cmd_value);
		end
	end

	// ==========================================================
	// Position-reached arming
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			arm_q       <= CCI_ARM_NONE;
			mask_q      <= 8'h00;
			move_open_q <= 1'b0;
		end
		else
		begin
			if (arm_req)
			begin
				// Program copies of this opcode are dropped
				arm_q  <= cmd_type == `CCI_TYPE_0 ? CCI_ARM_ONCE : CCI_ARM_ALL;
				mask_q <= cmd_value[7:0];
			end
			else if (move_done && move_open_q && arm_q == CCI_ARM_ONCE)
				arm_q <= CCI_ARM_NONE;
			// Only moves begun while armed may report; a done ends the move
			if (move_start && arm_q != CCI_ARM_NONE)
				move_open_q <= 1'b1;
			else if (move_done)
				move_open_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			evt_valid  <= 1'b0;
			evt_status <= 8'h00;
			evt_op     <= 8'h00;
			evt_value  <= '0;
		end
		else
		begin
			evt_valid <= move_done && move_open_q && arm_q != CCI_ARM_NONE;
			if (move_done && move_open_q)
			begin
				evt_status <= `CCI_ST_EVENT;
				evt_op     <= `CCI_OP_POS_REQ;
				evt_value  <= {24'h000000, mask_q};
			end
		end
	end

	// ==========================================================
	// Direct reply
	// Memory read answers one cycle late, once the address is registered
	logic read_pend_q;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			read_pend_q <= 1'b0;
		else
			read_pend_q <= act == CCI_ACT_READ_MEM;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rsp_valid   <= 1'b0;
			rsp_status  <= 8'h00;
			rsp_op      <= 8'h00;
			rsp_value   <= '0;
			rsp_special <= 1'b0;
		end
		else if (read_pend_q)
		begin
			rsp_valid   <= 1'b1;
			rsp_status  <= `CCI_ST_OK;
			rsp_op      <= `CCI_OP_READ_MEM;
			rsp_value   <= mem_rdata;
			rsp_special <= 1'b1;
		end
		else if (rsp_take)
		begin
			rsp_valid   <= 1'b1;
			rsp_status  <= `CCI_ST_OK;
			rsp_op      <= cmd_op;
			rsp_value   <= '0;
			rsp_special <= 1'b0;
			if (is_user)
				rsp_value <= user_value;
			else if (cmd_op == `CCI_OP_POS_REQ)
				rsp_value <= {24'h000000, cmd_value[7:0]};
			else if (cmd_op == `CCI_OP_STATUS)
			begin
				unique case (cmd_type)
					`CCI_TYPE_0: rsp_value <= status_word(mode_q, wait_flag, dl_ptr_q);
					`CCI_TYPE_1: rsp_value <= status_word(mode_q, wait_flag, prog_counter);
					`CCI_TYPE_2: rsp_value <= accu;
					`CCI_TYPE_3: rsp_value <= xreg;
					default:     rsp_status <= `CCI_ST_BAD_CMD;
				endcase
			end
			else if (cmd_op == `CCI_OP_VERSION)
			begin
				unique case (cmd_type)
					`CCI_TYPE_0:
					begin
						rsp_value   <= FW_TXT;
						rsp_special <= 1'b1;
					end
					`CCI_TYPE_1: rsp_value <= FW_BIN;
					default:     rsp_status <= `CCI_ST_BAD_CMD;
				endcase
			end
		end
		else
			rsp_valid <= 1'b0;
	end

endmodule

// [core/cci_defs.svh]
`ifndef CCI_DEFS_SVH
`define CCI_DEFS_SVH

// ==========================================================
// Opcodes
`define CCI_OP_UF_FIRST    8'h40
`define CCI_OP_UF_LAST     8'h47
`define CCI_OP_STOP        8'h80
`define CCI_OP_RUN         8'h81
`define CCI_OP_STEP        8'h82
`define CCI_OP_RESET       8'h83
`define CCI_OP_DL_ENTER    8'h84
`define CCI_OP_DL_EXIT     8'h85
`define CCI_OP_READ_MEM    8'h86
`define CCI_OP_STATUS      8'h87
`define CCI_OP_VERSION     8'h88
`define CCI_OP_FACTORY     8'h89
`define CCI_OP_POS_REQ     8'h8A
`define CCI_OP_SW_RESET    8'hFF

// ==========================================================
// Status codes and magic values
`define CCI_ST_OK          8'h64
`define CCI_ST_EVENT       8'h80
`define CCI_ST_BAD_CMD     8'h02
`define CCI_MAGIC          32'h000004D2

// ==========================================================
// Type field values
`define CCI_TYPE_0         8'h00
`define CCI_TYPE_1         8'h01
`define CCI_TYPE_2         8'h02
`define CCI_TYPE_3         8'h03

// ==========================================================
// Status reply layout
`define CCI_MODE_POS       24
`define CCI_WAIT_POS       16

`endif

// [core/cci_pkg.sv]
package cci_pkg;

	typedef enum logic [1:0]
	{
		CCI_MODE_STOP,
		CCI_MODE_RUN,
		CCI_MODE_STEP,
		CCI_MODE_DL
	} cci_mode_t;

	typedef enum logic [1:0]
	{
		CCI_ARM_NONE,
		CCI_ARM_ONCE,
		CCI_ARM_ALL
	} cci_arm_t;

	typedef enum logic [3:0]
	{
		CCI_ACT_NONE,
		CCI_ACT_STOP,
		CCI_ACT_RUN,
		CCI_ACT_STEP,
		CCI_ACT_RESET,
		CCI_ACT_READ_MEM,
		CCI_ACT_STORE,
		CCI_ACT_FACTORY,
		CCI_ACT_SW_RESET,
		CCI_ACT_USER,
		CCI_ACT_EXEC
	} cci_act_t;

endpackage

// [tb/cci_checker_assertions.sv]
`timescale 1ns/100ps
// ==========================================
// Port checker
module cci_checker
	import cci_pkg::*;
#(
	parameter int ADDR_W = 16
)
(
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        cmd_valid,
	input wire logic        cmd_from_prog,
	input wire logic [7:0]  cmd_op,
	input wire logic [7:0]  cmd_type,
	input wire logic [31:0] cmd_value,
	input wire logic [31:0] user_value,
	input wire logic        move_done,
	input wire logic        rsp_valid,
	input wire logic [7:0]  rsp_status,
	input wire logic [7:0]  rsp_op,
	input wire logic [31:0] rsp_value,
	input wire logic        evt_valid,
	input wire logic [7:0]  evt_status,
	input wire logic [7:0]  evt_op,
	input cci_mode_t        prog_mode,
	input wire logic        step_pulse,
	input wire logic        prog_clear,
	input wire logic        pc_load
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Download mode stores non-control commands instead of answering, so leave it out
	logic direct;
	assign direct = cmd_valid && !cmd_from_prog && prog_mode != CCI_MODE_DL;

	a_user_reply: assert property (direct && cmd_op inside {[8'h40:8'h47]} |=> rsp_valid
		&& rsp_status == 8'h64 && rsp_value == $past(user_value)) else $error("user reply");
	a_echo_mask: assert property (direct && cmd_op == 8'h8A |=> rsp_valid
		&& rsp_op == 8'h8A && rsp_value == {24'h000000, $past(cmd_value[7:0])})
		else $error("request echo");
	a_evt_source: assert property (evt_valid |-> $past(move_done)
		&& evt_status == 8'h80 && evt_op == 8'h8A) else $error("arrival reply");
	a_prog_refused: assert property (cmd_valid && cmd_from_prog
		&& cmd_op inside {[8'h80:8'h8A]} |=> !rsp_valid && !pc_load) else $error("stored ctrl");
	a_stop_halts: assert property (direct && cmd_op == 8'h80
		|=> prog_mode == CCI_MODE_STOP) else $error("stop");
	a_run_loads: assert property (direct && cmd_op == 8'h81 && cmd_type == 8'h01
		|=> pc_load && prog_mode == CCI_MODE_RUN) else $error("run");
	a_step_once: assert property (direct && cmd_op == 8'h82 |=> step_pulse)
		else $error("step");
	a_reset_clears: assert property (direct && cmd_op == 8'h83
		|=> prog_clear && prog_mode == CCI_MODE_STOP) else $error("reset");
	a_factory_quiet: assert property (cmd_valid && cmd_op == 8'h89 |=> !rsp_valid)
		else $error("factory reply");
	a_evt_single: assert property (evt_valid |=> !evt_valid)
		else $error("double arrival");
endmodule

bind cci_interp cci_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

// [tb/cci_host_model.sv]
`timescale 1ns/100ps
// ==========================================
// Host side of the command link
module cci_host_model
(
	input wire logic   clk,
	output logic       cmd_valid,
	output logic       cmd_from_prog,
	output logic [7:0] cmd_op,
	output logic [7:0] cmd_type,
	output logic [7:0] cmd_motor,
	output logic [31:0] cmd_value
);
	initial
	begin
		{cmd_valid, cmd_from_prog, cmd_op, cmd_type, cmd_motor, cmd_value} = '0;
	end
	task send(input logic [7:0] op, input logic [7:0] t, input logic [31:0] v, input logic fp);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_from_prog <= fp;
		cmd_op <= op;
		cmd_type <= t;
		cmd_motor <= 8'h00;
		cmd_value <= v;
		@(posedge clk);
		// Released opcode and value show garbage, not the last command
		cmd_valid <= 1'b0;
		cmd_op <= ~op;
		cmd_value <= ~v;
	endtask
endmodule

// [tb/test_control_command_interpreter.sv]
`timescale 1ns/100ps
module test_control_command_interpreter;
	import cci_pkg::*;
	logic        clk = 0, resetn = 0, move_start = 0, move_done = 0, wait_flag;
	logic        cmd_valid, cmd_from_prog, rsp_valid, rsp_special, evt_valid, step_pulse;
	logic        prog_clear, pc_load, mem_we, factory_pulse, sw_reset_pulse, exec_pulse;
	logic [7:0]  cmd_op, cmd_type, cmd_motor, rsp_status, rsp_op, evt_status, evt_op;
	logic [31:0] cmd_value, rsp_value, evt_value, mem_rdata, accu, xreg;
	logic [31:0] user_value = 32'h00C0FFEE;
	logic [15:0] prog_counter, pc_value, mem_addr;
	logic [63:0] mem_wdata;
	cci_mode_t   prog_mode;
	int          errors = 0, compares = 0;
	assign mem_rdata = 32'h13572468;
	assign accu = 32'hA5A50001;
	assign xreg = 32'h5A5A0002;
	assign wait_flag = 1'b1;
	assign prog_counter = 16'h0042;
	always #20 clk = ~clk;
	cci_interp #(.FW_BIN(32'h00000A0B)) uut (.*);
	cci_host_model host (.*);
	// ==========================================
	// Shared helpers
	task chk(input logic [63:0] s, input logic [63:0] e);
		compares++;
		if (s !== e)
		begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task cmd(input logic [7:0] op, input logic [7:0] t, input logic [31:0] v);
		host.send(op, t, v, 1'b0);
		#1;
	endtask
	task mv(input logic exp);
		@(posedge clk) move_start <= 1'b1;
		@(posedge clk) move_start <= 1'b0;
		repeat (3) @(posedge clk);
		move_done <= 1'b1;
		@(posedge clk) move_done <= 1'b0;
		#1 chk(evt_valid, exp);
		if (exp)
			chk({evt_status, evt_op, evt_value}, {8'h80, 8'h8A, 32'h1});
		@(posedge clk) #1 chk(evt_valid, 0);
	endtask
	// ==========================================
	// Scenarios
	task t_user;
		for (int i = 0; i < 8; i++)
		begin
			cmd(8'h40 + 8'(i), 8'h00, 32'h0);
			chk({rsp_valid, rsp_status, rsp_value}, {1'b1, 8'h64, user_value});
		end
	endtask
	task t_event;
		cmd(8'h8A, 8'h00, 32'h1);
		chk({rsp_valid, rsp_status, rsp_op, rsp_value}, {9'h164, 8'h8A, 32'h1});
		mv(1);
		mv(0);
		cmd(8'h8A, 8'h01, 32'h1);
		mv(1);
		mv(1);
	endtask
	task t_refuse;
		cmd(8'h8A, 8'h00, 32'h1);
		mv(1);
		host.send(8'h8A, 8'h01, 32'h1, 1'b1);
		#1 chk(rsp_valid, 0);
		mv(0);
		host.send(8'h81, 8'h01, 32'h5, 1'b1);
		#1 chk({rsp_valid, pc_load}, 0);
	endtask
	task t_program;
		cmd(8'h81, 8'h01, 32'h5);
		chk({pc_load, pc_value, prog_mode}, {17'h10005, CCI_MODE_RUN});
		cmd(8'h80, 8'h00, 32'h0);
		chk(prog_mode, CCI_MODE_STOP);
		cmd(8'h81, 8'h00, 32'h0);
		chk({pc_load, prog_mode}, {1'b0, CCI_MODE_RUN});
		cmd(8'h82, 8'h00, 32'h0);
		chk(step_pulse, 1);
		@(posedge clk) #1 chk(prog_mode, CCI_MODE_STOP);
		cmd(8'h83, 8'h00, 32'h0);
		chk({prog_clear, prog_mode}, {1'b1, CCI_MODE_STOP});
		cmd(8'h84, 8'h00, 32'h20);
		chk(prog_mode, CCI_MODE_DL);
		cmd(8'h04, 8'h01, 32'h7);
		chk({mem_we, rsp_valid, mem_addr}, {2'b10, 16'h0020});
		chk(mem_wdata, {8'h04, 8'h01, 16'h0, 32'h7});
		cmd(8'h80, 8'h00, 32'h0);
		chk({rsp_valid, prog_mode}, {1'b1, CCI_MODE_DL});
		cmd(8'h85, 8'h00, 32'h0);
		chk(prog_mode, CCI_MODE_STOP);
		cmd(8'h04, 8'h01, 32'h7);
		chk({mem_we, exec_pulse}, 2'b01);
	endtask
	task t_query;
		cmd(8'h86, 8'h00, 32'h3);
		chk({rsp_valid, mem_addr}, {1'b0, 16'h0003});
		@(posedge clk) #1 chk({rsp_valid, rsp_special, rsp_value}, {2'b11, mem_rdata});
		cmd(8'h87, 8'h00, 32'h0);
		chk({rsp_status, rsp_op, rsp_value}, {16'h6487, 32'h00010021});
		cmd(8'h87, 8'h02, 32'h0);
		chk(rsp_value, accu);
		cmd(8'h87, 8'h03, 32'h0);
		chk(rsp_value, xreg);
		cmd(8'h87, 8'h01, 32'h0);
		chk(rsp_value, 32'h00010042);
		cmd(8'h87, 8'h04, 32'h0);
		chk(rsp_status, 8'h02);
		cmd(8'h88, 8'h01, 32'h0);
		chk(rsp_value, 32'h00000A0B);
		cmd(8'h88, 8'h00, 32'h0);
		chk(rsp_special, 1);
		cmd(8'h88, 8'h02, 32'h0);
		chk({rsp_valid, rsp_status}, 9'h102);
	endtask
	task t_system;
		// Host moves on at once, no reply is awaited
		cmd(8'h89, 8'h00, 32'd1234);
		chk({factory_pulse, rsp_valid}, 2'b10);
		cmd(8'h89, 8'h00, 32'd5);
		chk(factory_pulse, 0);
		cmd(8'hFF, 8'h00, 32'd1234);
		chk(sw_reset_pulse, 1);
		cmd(8'hFF, 8'h00, 32'd5);
		chk({sw_reset_pulse, rsp_valid}, 2'b01);
	endtask
	task final_report;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		t_user;
		t_event;
		t_refuse;
		t_program;
		t_query;
		t_system;
		final_report;
	end
	initial
	begin
		#400000;
		errors++;
		final_report;
	end
endmodule
